// ===== design/uart_core_pkg.sv
// Shared constants and types of the serial UART core
// Function
// - Frames carry eight or nine data bits
// - Even, odd or no parity both directions
// - Transmitter sends one or two stop bits
// - Bit rate from 8-bit programmable divisor
// - Receive buffer holds two characters
// - Address detect interrupts on last bit one
// - Interrupt on tx empty, idle, rx, overrun, address
// - Receive line activity raises wake-up event
// - Pins driven only when mode, enable, direction set
// - Written character shifted out on TX LSB first
// - RX bits assembled LSB first, then transferred
// - One data address: write transmits, read receives
// - Mode bit 4 selects UART over synchronous modes
// - UART registers reachable only in UART mode
// - Status read-only; idle and empty reset high
// - Parity error set when enabled, sequence clears
// - Noise set with data available, not overrun
// - Framing error flags current bad character
// - Overrun sets flag and blocks further transfers
// - Receiver idle low from start through stop
// - Transfer sets data-available and errors together
// - Data-available clears by status then read of last character
// - Disable flushes, resets counters, flags, enables
// - Ninth bits kept in receive/transmit fields
// - Transmit empty set on load, sequence clears
package uart_core_pkg;

    // ----------------------------------------
    // Register word indexes (byte address = index * 4)
    // ----------------------------------------
    localparam logic [2:0] REG_MODE_IDX = 3'h0;
    localparam logic [2:0] REG_STATUS_IDX = 3'h1;
    localparam logic [2:0] REG_CTRL1_IDX = 3'h2;
    localparam logic [2:0] REG_CTRL2_IDX = 3'h3;
    localparam logic [2:0] REG_DATA_IDX = 3'h4;
    localparam logic [2:0] REG_BAUD_IDX = 3'h5;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int MODE_UART_BIT = 4;
    localparam int C1_ENABLE = 7;
    localparam int C1_NINE_BIT = 6;
    localparam int C1_PARITY_EN = 5;
    localparam int C1_ODD_PARITY = 4;
    localparam int C1_TWO_STOP = 3;
    localparam int C1_SEND_BREAK = 2;
    localparam int C1_RX_NINTH = 1;
    localparam int C1_TX_NINTH = 0;
    localparam int C2_TX_EN = 7;
    localparam int C2_RX_EN = 6;
    localparam int C2_HIGH_SPEED = 5;
    localparam int C2_ADDR_DETECT = 4;
    localparam int C2_WAKE_EN = 3;
    localparam int C2_RX_IE = 2;
    localparam int C2_TX_IDLE_IE = 1;
    localparam int C2_TX_EMPTY_IE = 0;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] MODE_RESET = 8'hE0;
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [7:0] CTRL2_RESET = 8'h00;
    localparam logic [7:0] BAUD_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h0B;

    // ----------------------------------------
    // Timing counts
    // ----------------------------------------
    localparam logic [3:0] PHASE_LAST = 4'hF;
    localparam logic [3:0] VOTE_FIRST = 4'h7;
    localparam logic [3:0] VOTE_LAST = 4'h9;
    localparam logic [1:0] LOW_SPEED_LAST = 2'h3;
    localparam int RX_FIFO_DEPTH = 2;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic ninth;
        logic [7:0] data;
    } rx_char_t;

    typedef struct packed {
        logic perr;
        logic nf;
        logic ferr;
        logic oerr;
        logic ridle;
        logic rxif;
        logic tidle;
        logic txif;
    } status_t;

endpackage

// ===== design/uart_baud_tick.sv
// Oversampling tick generator driven by the baud divisor
`timescale 1ns/10ps
module uart_baud_tick (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic [7:0] divisor,
    input wire logic high_speed,
    output logic sample_tick
);
    import uart_core_pkg::*;

    typedef struct packed {
        logic [7:0] count;
        logic [1:0] prescale;
        logic tick;
    } baud_state_t;

    baud_state_t s;
    baud_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (!run) begin
            next_s.count = 8'h00;
            next_s.prescale = 2'h0;
        end else if (s.count == 8'h00) begin
            next_s.count = divisor;
            if (high_speed || s.prescale == LOW_SPEED_LAST) begin
                next_s.tick = 1'b1;
                next_s.prescale = 2'h0;
            end else begin
                next_s.prescale = s.prescale + 2'h1;
            end
        end else begin
            next_s.count = s.count - 8'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign sample_tick = s.tick;
endmodule

// ===== design/uart_rx_fifo.sv
// Small receive character buffer with flush
`timescale 1ns/10ps
module uart_rx_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 2
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic flush,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    output logic [WIDTH-1:0] head,
    output logic empty,
    output logic full,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    import uart_core_pkg::*;

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int LW = $clog2(DEPTH+1);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [LW-1:0] LEVEL_FULL = LW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [LW-1:0] count;
    } fifo_state_t;

    fifo_state_t s;
    fifo_state_t next_s;

    always_comb begin
        next_s = s;
        if (flush) begin
            next_s.wr = '0;
            next_s.rd = '0;
            next_s.count = '0;
        end else begin
            if (push && s.count != LEVEL_FULL) begin
                next_s.mem[s.wr] = push_data;
                next_s.wr = (s.wr == PTR_LAST) ? '0 : s.wr + PW'(1);
                next_s.count = next_s.count + LW'(1);
            end
            if (pop && s.count != '0) begin
                next_s.rd = (s.rd == PTR_LAST) ? '0 : s.rd + PW'(1);
                next_s.count = next_s.count - LW'(1);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign head = s.mem[s.rd];
    assign empty = (s.count == '0);
    assign full = (s.count == LEVEL_FULL);
    assign level = s.count;
endmodule

// ===== design/uart_serial_core_status.sv
// UART core: Wishbone register file, transmitter, receiver
`timescale 1ns/10ps
module uart_serial_core_status (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [4:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic rx_pin,
    output logic rx_input_enable,
    output logic tx_pin,
    output logic tx_output_enable,
    output logic serial_irq,
    output logic wakeup_event
);
    import uart_core_pkg::*;

    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;
    typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] ctrl1;
        logic [7:0] ctrl2;
        logic [7:0] baud;
        logic [7:0] tx_hold;
        status_t st;
        status_t seen;
        logic ack;
        logic [7:0] rdata;
        logic rx_s1;
        logic rx_s2;
        logic rx_s3;
        logic rx_lvl;
        rx_state_t rx_st;
        logic [3:0] rx_ph;
        logic [3:0] rx_bit;
        logic [8:0] rx_sh;
        logic [1:0] rx_votes;
        logic rx_noise;
        logic rx_par_bad;
        tx_state_t tx_st;
        logic [3:0] tx_ph;
        logic [3:0] tx_bit;
        logic [3:0] tx_len;
        logic [11:0] tx_sh;
        logic tx_line;
        logic wake;
    } core_state_t;

    core_state_t s;
    core_state_t next_s;

    logic tick;
    logic fifo_push;
    logic fifo_pop;
    logic fifo_flush;
    rx_char_t fifo_in;
    rx_char_t fifo_head;
    logic fifo_empty;
    logic fifo_full;
    logic [1:0] fifo_level;

    logic uart_mode;
    logic active;
    logic rx_run;
    logic tx_run;
    logic nine;
    logic addr_char;

    // ----------------------------------------
    // Enables and pin control
    // ----------------------------------------
    assign uart_mode = s.mode[MODE_UART_BIT];
    assign active = uart_mode && s.ctrl1[C1_ENABLE];
    assign rx_run = active && s.ctrl2[C2_RX_EN];
    assign tx_run = active && s.ctrl2[C2_TX_EN];
    assign nine = s.ctrl1[C1_NINE_BIT];

    assign rx_input_enable = rx_run;
    assign tx_output_enable = tx_run;
    assign tx_pin = s.tx_line;
    assign dat_o = {24'h000000, s.rdata};
    assign ack_o = s.ack;
    assign wakeup_event = s.wake;

    // Last data bit of the character at the head of the buffer
    assign addr_char = nine ? fifo_head.ninth : fifo_head.data[7];

    // ----------------------------------------
    // Interrupt request
    // ----------------------------------------
    always_comb begin
        serial_irq = 1'b0;
        if (active) begin
            if (s.ctrl2[C2_TX_EMPTY_IE] && s.st.txif) begin
                serial_irq = 1'b1;
            end
            if (s.ctrl2[C2_TX_IDLE_IE] && s.st.tidle) begin
                serial_irq = 1'b1;
            end
            if (s.ctrl2[C2_RX_IE] && s.st.oerr) begin
                serial_irq = 1'b1;
            end
            if (s.ctrl2[C2_RX_IE] && s.st.rxif && (!s.ctrl2[C2_ADDR_DETECT] || addr_char)) begin
                serial_irq = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Sub-blocks
    // ----------------------------------------
    uart_baud_tick baud_gen (
        .clock(clock),
        .sys_rst(sys_rst),
        .run(active),
        .divisor(s.baud),
        .high_speed(s.ctrl2[C2_HIGH_SPEED]),
        .sample_tick(tick)
    );

    uart_rx_fifo #(
        .WIDTH(9),
        .DEPTH(RX_FIFO_DEPTH)
    ) rx_buffer (
        .clock(clock),
        .sys_rst(sys_rst),
        .flush(fifo_flush),
        .push(fifo_push),
        .push_data(fifo_in),
        .pop(fifo_pop),
        .head(fifo_head),
        .empty(fifo_empty),
        .full(fifo_full),
        .level(fifo_level)
    );

    assign fifo_in = {s.rx_sh[8], s.rx_sh[7:0]};

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        logic access;
        logic wr;
        logic bit_val;
        logic noise_bit;
        logic par;
        logic [11:0] frame;
        logic [3:0] pos;
        next_s = s;
        access = cyc_i && stb_i && !s.ack;
        wr = we_i && sel_i[0];
        bit_val = 1'b0;
        noise_bit = 1'b0;
        par = 1'b0;
        frame = 12'hFFF;
        pos = 4'h9;
        fifo_push = 1'b0;
        fifo_pop = 1'b0;
        fifo_flush = 1'b0;
        next_s.ack = 1'b0;
        next_s.wake = 1'b0;

        // RX synchroniser: level changes once stages two and three agree
        next_s.rx_s1 = rx_pin;
        next_s.rx_s2 = s.rx_s1;
        next_s.rx_s3 = s.rx_s2;
        if (s.rx_s2 == s.rx_s3) begin
            next_s.rx_lvl = s.rx_s2;
        end
        if (s.ctrl2[C2_WAKE_EN] && rx_run && s.rx_s2 == s.rx_s3 && !s.rx_s2 && s.rx_lvl) begin
            next_s.wake = 1'b1;
        end

        // ----------------------------------------
        // Register access (clears first, hardware sets below win)
        // ----------------------------------------
        if (access) begin
            next_s.ack = 1'b1;
            next_s.rdata = 8'h00;
            if (adr_i[4:2] == REG_MODE_IDX) begin
                next_s.rdata = s.mode;
                if (wr) begin
                    next_s.mode = dat_i[7:0];
                end
            end else if (uart_mode) begin
                case (adr_i[4:2])
                    REG_STATUS_IDX: begin
                        if (!we_i) begin
                            next_s.rdata = s.st;
                            next_s.seen = s.st;
                        end
                    end
                    REG_CTRL1_IDX: begin
                        next_s.rdata = {s.ctrl1[7:2], fifo_head.ninth, s.ctrl1[C1_TX_NINTH]};
                        if (wr) begin
                            next_s.ctrl1 = {dat_i[7:2], 1'b0, dat_i[0]};
                        end
                    end
                    REG_CTRL2_IDX: begin
                        next_s.rdata = s.ctrl2;
                        if (wr) begin
                            next_s.ctrl2 = dat_i[7:0];
                            if (dat_i[C2_TX_EN]) begin
                                next_s.st.txif = next_s.st.txif | (s.tx_st == TX_IDLE && s.st.txif);
                            end
                        end
                    end
                    REG_DATA_IDX: begin
                        // Error flags clear on a data access after the status read saw them
                        if (s.seen.perr) next_s.st.perr = 1'b0;
                        if (s.seen.nf) next_s.st.nf = 1'b0;
                        if (s.seen.ferr) next_s.st.ferr = 1'b0;
                        if (s.seen.oerr) next_s.st.oerr = 1'b0;
                        if (we_i) begin
                            if (sel_i[0]) begin
                                next_s.tx_hold = dat_i[7:0];
                            end
                            if (s.seen.txif) next_s.st.txif = 1'b0;
                            if (s.seen.tidle) next_s.st.tidle = 1'b0;
                        end else begin
                            next_s.rdata = fifo_head.data;
                            fifo_pop = !fifo_empty;
                            if (s.seen.rxif && fifo_level <= 2'h1) begin
                                next_s.st.rxif = 1'b0;
                            end
                        end
                        next_s.seen = '0;
                    end
                    REG_BAUD_IDX: begin
                        next_s.rdata = s.baud;
                        if (wr) begin
                            next_s.baud = dat_i[7:0];
                        end
                    end
                    default: begin
                        next_s.rdata = 8'h00;
                    end
                endcase
            end
        end

        // ----------------------------------------
        // Receiver: 16 phases per bit, majority of phases 7..9
        // ----------------------------------------
        case (s.rx_st)
            RX_IDLE: begin
                if (rx_run && !s.rx_lvl) begin
                    next_s.rx_st = RX_START;
                    next_s.rx_ph = 4'h0;
                    next_s.rx_votes = 2'h0;
                    next_s.rx_noise = 1'b0;
                    next_s.rx_sh = 9'h000;
                    next_s.rx_bit = 4'h0;
                    next_s.st.ridle = 1'b0;
                end
            end
            default: begin
                if (tick) begin
                    next_s.rx_ph = s.rx_ph + 4'h1;
                    if (s.rx_ph >= VOTE_FIRST && s.rx_ph <= VOTE_LAST && s.rx_lvl) begin
                        next_s.rx_votes = s.rx_votes + 2'h1;
                    end
                    if (s.rx_ph == PHASE_LAST) begin
                        bit_val = s.rx_votes[1];
                        noise_bit = s.rx_votes[1] ^ s.rx_votes[0];
                        next_s.rx_votes = 2'h0;
                        next_s.rx_noise = s.rx_noise | noise_bit;
                        case (s.rx_st)
                            RX_START: begin
                                if (bit_val) begin
                                    next_s.rx_st = RX_IDLE;
                                    next_s.st.ridle = 1'b1;
                                end else begin
                                    next_s.rx_st = RX_DATA;
                                end
                            end
                            RX_DATA: begin
                                next_s.rx_sh[s.rx_bit] = bit_val;
                                next_s.rx_bit = s.rx_bit + 4'h1;
                                if (s.rx_bit == (nine ? 4'h8 : 4'h7)) begin
                                    next_s.rx_st = s.ctrl1[C1_PARITY_EN] ? RX_PARITY : RX_STOP;
                                end
                            end
                            RX_PARITY: begin
                                next_s.rx_par_bad = (^s.rx_sh ^ bit_val) != s.ctrl1[C1_ODD_PARITY];
                                next_s.rx_st = RX_STOP;
                            end
                            default: begin
                                next_s.rx_st = RX_IDLE;
                                next_s.st.ridle = 1'b1;
                                if (s.st.oerr || fifo_full) begin
                                    next_s.st.oerr = 1'b1;
                                end else begin
                                    fifo_push = 1'b1;
                                    next_s.st.rxif = 1'b1;
                                    if (!bit_val) next_s.st.ferr = 1'b1;
                                    if (s.ctrl1[C1_PARITY_EN] && s.rx_par_bad) next_s.st.perr = 1'b1;
                                    if (s.rx_noise | noise_bit) next_s.st.nf = 1'b1;
                                end
                            end
                        endcase
                    end
                end
            end
        endcase

        // ----------------------------------------
        // Transmitter frame: start, data, ninth, parity, stops
        // ----------------------------------------
        frame[0] = 1'b0;
        frame[8:1] = s.tx_hold;
        par = ^s.tx_hold ^ (nine & s.ctrl1[C1_TX_NINTH]) ^ s.ctrl1[C1_ODD_PARITY];
        if (nine) begin
            frame[9] = s.ctrl1[C1_TX_NINTH];
            pos = 4'hA;
        end
        if (s.ctrl1[C1_PARITY_EN]) begin
            frame[pos] = par;
            pos = pos + 4'h1;
        end

        case (s.tx_st)
            TX_IDLE: begin
                if (tx_run && !s.st.txif) begin
                    next_s.tx_sh = frame;
                    next_s.tx_len = pos + {3'h0, s.ctrl1[C1_TWO_STOP]};
                    next_s.st.txif = 1'b1;
                    next_s.st.tidle = 1'b0;
                    next_s.tx_st = TX_SEND;
                    next_s.tx_ph = 4'h0;
                    next_s.tx_bit = 4'h0;
                end
            end
            default: begin
                if (tick) begin
                    next_s.tx_ph = s.tx_ph + 4'h1;
                    if (s.tx_ph == PHASE_LAST) begin
                        next_s.tx_sh = {1'b1, s.tx_sh[11:1]};
                        next_s.tx_bit = s.tx_bit + 4'h1;
                        if (s.tx_bit == s.tx_len) begin
                            next_s.tx_st = TX_IDLE;
                        end
                    end
                end
            end
        endcase
        if (next_s.tx_st == TX_IDLE && s.tx_st == TX_IDLE && s.st.txif && !s.ctrl1[C1_SEND_BREAK]) begin
            next_s.st.tidle = 1'b1;
        end
        if (next_s.tx_st == TX_SEND) begin
            next_s.tx_line = next_s.tx_sh[0];
        end else begin
            next_s.tx_line = !(tx_run && s.ctrl1[C1_SEND_BREAK]);
        end

        // ----------------------------------------
        // UART disabled: flush and return to reset flags
        // ----------------------------------------
        if (!next_s.ctrl1[C1_ENABLE]) begin
            next_s.ctrl2[C2_TX_EN] = 1'b0;
            next_s.ctrl2[C2_RX_EN] = 1'b0;
            next_s.ctrl1[C1_SEND_BREAK] = 1'b0;
            next_s.st = STATUS_RESET;
            next_s.seen = '0;
            fifo_flush = 1'b1;
            fifo_push = 1'b0;
            next_s.rx_st = RX_IDLE;
            next_s.tx_st = TX_IDLE;
            next_s.tx_line = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s <= '0;
            s.mode <= MODE_RESET;
            s.ctrl1 <= CTRL1_RESET;
            s.ctrl2 <= CTRL2_RESET;
            s.baud <= BAUD_RESET;
            s.st <= STATUS_RESET;
            s.rx_s1 <= 1'b1;
            s.rx_s2 <= 1'b1;
            s.rx_s3 <= 1'b1;
            s.rx_lvl <= 1'b1;
            s.rx_st <= RX_IDLE;
            s.tx_st <= TX_IDLE;
            s.tx_line <= 1'b1;
        end else begin
            s <= next_s;
        end
    end
endmodule

// ===== sim/uart_core_monitor.sv
// Port checker for the serial UART core
`timescale 1ns/10ps
module uart_core_monitor (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [4:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic rx_pin,
    input wire logic rx_input_enable,
    input wire logic tx_pin,
    input wire logic tx_output_enable,
    input wire logic serial_irq,
    input wire logic wakeup_event
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
    a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
    a_dat_hold: assert property (!ack_o |-> $stable(dat_o) && dat_o[31:8] == 24'h0)
        else $error("read data moved");
    a_reset_outs: assert property ($past(sys_rst) |-> tx_pin && !tx_output_enable && !serial_irq)
        else $error("bad reset outputs");
    a_idle_high: assert property (!tx_output_enable && $past(!tx_output_enable) |-> tx_pin)
        else $error("tx low while off");
    a_wake_cause: assert property (wakeup_event |-> $past(rx_input_enable) ##1 !wakeup_event)
        else $error("bad wake pulse");
    a_start_len: assert property ($fell(tx_pin) && tx_output_enable |=> !tx_pin [*8])
        else $error("short start bit");
    c_write: cover property (ack_o && we_i);
    c_wake: cover property (wakeup_event);
    c_start: cover property ($fell(tx_pin) && tx_output_enable);
endmodule

bind uart_serial_core_status uart_core_monitor mon (.*);

// ===== sim/serial_peer.sv
// Far serial device: sends frames on rx, captures tx frames
`timescale 1ns/10ps
module serial_peer (
    input wire logic clock,
    input wire logic line_in,
    output logic line_out = 1'b1
);
    task automatic send(input logic [7:0] d, input logic stop);
        logic [10:0] f;
        f = {1'b1, stop, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            line_out <= f[i];
            repeat (16) @(posedge clock);
        end
    endtask
    task automatic grab(output logic [7:0] d);
        @(negedge line_in);
        repeat (8) @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(posedge clock);
            d[i] = line_in;
        end
    endtask
endmodule

// ===== sim/tb_top.sv
// Self-checking bench for the serial UART core
`timescale 1ns/10ps
`define CHK(n, e, v) begin num_checks++; if ((v) !== (e)) begin num_errors++; \
    $display("Error %s expected %h seen %h", n, e, v); end end
module tb_top;
    import uart_core_pkg::*;
    logic clock = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, ack, rx, tx_pin, tx_oe, rx_en, irq, wake;
    logic [2:0] adr = 0;
    logic [7:0] dat = 0, q;
    logic [31:0] dat_o;
    int num_errors = 0, num_checks = 0, wakes = 0;
    wire tx_line = tx_oe ? tx_pin : 1'b1;
    always #12.5 clock = ~clock;
    always @(posedge clock) if (wake === 1'b1) wakes++;
    uart_serial_core_status uut (.clock(clock), .sys_rst(sys_rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i({adr, 2'b00}), .sel_i(4'hF), .dat_i({24'h0, dat}), .dat_o(dat_o), .ack_o(ack), .rx_pin(rx),
        .rx_input_enable(rx_en), .tx_pin(tx_pin), .tx_output_enable(tx_oe), .serial_irq(irq), .wakeup_event(wake));
    serial_peer peer (.clock(clock), .line_in(tx_line), .line_out(rx));
    task automatic bus(input logic w, input logic [2:0] i, input logic [7:0] d);
        @(posedge clock);
        {cyc, stb, we, adr, dat} <= {2'b11, w, i, d};
        @(posedge clock);
        while (ack !== 1'b1) @(posedge clock);
        q = dat_o[7:0];
        {cyc, stb} <= 2'b00;
    endtask
    task automatic rd(input logic [2:0] i, input logic [7:0] e, input string n);
        bus(1'b0, i, 8'h00);
        `CHK(n, e, q)
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic t_regs();
        rd(REG_STATUS_IDX, 8'h00, "locked");
        rd(REG_MODE_IDX, MODE_RESET, "mode");
        bus(1'b1, REG_MODE_IDX, MODE_RESET | 8'h10);
        rd(REG_STATUS_IDX, STATUS_RESET, "status");
        bus(1'b1, REG_STATUS_IDX, 8'h00);
        rd(REG_STATUS_IDX, STATUS_RESET, "status ro");
        rd(3'h6, 8'h00, "unmapped");
        bus(1'b1, REG_CTRL1_IDX, 8'h80);
        bus(1'b1, REG_CTRL2_IDX, 8'hEC);
        `CHK("tx oe", 1'b1, tx_oe)
        `CHK("rx en", 1'b1, rx_en)
        $display("regs done");
    endtask
    task automatic t_tx();
        logic [7:0] d;
        fork
            peer.grab(d);
            begin
                rd(REG_STATUS_IDX, STATUS_RESET, "st tx");
                bus(1'b1, REG_DATA_IDX, 8'hA5);
            end
        join
        `CHK("tx char", 8'hA5, d)
        $display("tx done");
    endtask
    task automatic t_rx();
        peer.send(8'h3C, 1'b1);
        `CHK("irq", 1'b1, irq)
        `CHK("wake", 1'b1, wakes > 0)
        rd(REG_STATUS_IDX, 8'h0F, "st rx");
        rd(REG_DATA_IDX, 8'h3C, "rx char");
        rd(REG_STATUS_IDX, STATUS_RESET, "st clr");
        `CHK("irq off", 1'b0, irq)
        $display("rx done");
    endtask
    task automatic t_err();
        peer.send(8'h55, 1'b0);
        rd(REG_STATUS_IDX, 8'h2F, "st ferr");
        rd(REG_DATA_IDX, 8'h55, "bad char");
        rd(REG_STATUS_IDX, STATUS_RESET, "ferr clr");
        $display("err done");
    endtask
    task automatic t_ovr();
        peer.send(8'h11, 1'b1);
        peer.send(8'h22, 1'b1);
        peer.send(8'h33, 1'b1);
        rd(REG_STATUS_IDX, 8'h1F, "st ovr");
        rd(REG_DATA_IDX, 8'h11, "first");
        rd(REG_STATUS_IDX, 8'h0F, "st left");
        rd(REG_DATA_IDX, 8'h22, "second");
        rd(REG_STATUS_IDX, STATUS_RESET, "st empty");
        $display("ovr done");
    endtask
    task automatic t_par();
        bus(1'b1, REG_CTRL1_IDX, 8'hA0);
        peer.send(8'h55, 1'b1);
        repeat (16) @(posedge clock);
        rd(REG_STATUS_IDX, 8'h8F, "st perr");
        rd(REG_DATA_IDX, 8'h55, "par char");
        rd(REG_STATUS_IDX, STATUS_RESET, "perr clr");
        $display("par done");
    endtask
    task automatic t_off();
        bus(1'b1, REG_CTRL1_IDX, 8'h00);
        rd(REG_STATUS_IDX, STATUS_RESET, "st off");
        rd(REG_CTRL2_IDX, 8'h2C, "ctrl2 off");
        `CHK("oe off", 1'b0, tx_oe)
        `CHK("rx off", 1'b0, rx_en)
        $display("off done");
    endtask
    initial begin
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        t_regs();
        t_tx();
        t_rx();
        t_err();
        t_ovr();
        t_par();
        t_off();
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        finish_test();
    end
endmodule
